// ===== hdl/dpi_pkg.sv
// Constants, register map and carrier types of the data path init sequencer.
package dpi_pkg;

  localparam int DPI_LANES = 8;
  localparam int DPI_CLK_MHZ = 250;

  // Data path set-up time and transmitter turn-on time, least values.
  localparam int DPI_INIT_TIME_NS = 1000;
  localparam int DPI_TXON_TIME_NS = 200;
  localparam int DPI_INIT_CYC = (DPI_INIT_TIME_NS * DPI_CLK_MHZ + 999) / 1000;
  localparam int DPI_TXON_CYC = (DPI_TXON_TIME_NS * DPI_CLK_MHZ + 999) / 1000;

  // Register byte offsets.
  localparam logic [7:0] DPI_OFS_STAGED = 8'h00;
  localparam logic [7:0] DPI_OFS_ACTIVE = 8'h04;
  localparam logic [7:0] DPI_OFS_COMMIT = 8'h08;
  localparam logic [7:0] DPI_OFS_CFG_ERR = 8'h0c;
  localparam logic [7:0] DPI_OFS_SHUTDOWN = 8'h10;
  localparam logic [7:0] DPI_OFS_PATH_STATE = 8'h14;
  localparam logic [7:0] DPI_OFS_INT_STAT = 8'h18;
  localparam logic [7:0] DPI_OFS_INT_CLR = 8'h1c;
  localparam logic [7:0] DPI_OFS_INT_EN = 8'h20;
  localparam logic [7:0] DPI_OFS_TX_DIS = 8'h24;

  // Reset values.
  localparam logic [31:0] DPI_STAGED_RST = 32'h0000_0000;
  localparam logic [7:0] DPI_SHUTDOWN_RST = 8'h00;
  localparam logic [7:0] DPI_INT_EN_RST = 8'hff;
  localparam logic [7:0] DPI_TX_DIS_RST = 8'h00;

  // Commit trigger value, one bit per lane.
  localparam logic [7:0] DPI_COMMIT_ALL = 8'hff;

  // Application select codes that this device accepts, one bit per code.
  localparam logic [15:0] DPI_APP_VALID = 16'h000e;

  // Per-lane configuration error codes.
  localparam logic [3:0] DPI_ERR_NONE = 4'h0;
  localparam logic [3:0] DPI_ERR_ACCEPTED = 4'h1;
  localparam logic [3:0] DPI_ERR_BAD_CODE = 4'h2;
  localparam logic [3:0] DPI_ERR_BUSY = 4'h3;

  // Per-lane state codes as software reads them.
  localparam logic [3:0] DPI_CODE_INACTIVE = 4'h1;
  localparam logic [3:0] DPI_CODE_INITIALIZING = 4'h2;
  localparam logic [3:0] DPI_CODE_READY_IDLE = 4'h3;
  localparam logic [3:0] DPI_CODE_TX_ON = 4'h4;
  localparam logic [3:0] DPI_CODE_ACTIVE = 4'h5;

  localparam logic [1:0] DPI_RESP_OKAY = 2'b00;
  localparam logic [1:0] DPI_RESP_SLVERR = 2'b10;

  typedef enum logic [4:0] {
    PATH_STATE_INACTIVE = 5'b00001,
    PATH_STATE_INITIALIZING = 5'b00010,
    PATH_STATE_READY_IDLE = 5'b00100,
    PATH_STATE_TRANSMITTER_ON = 5'b01000,
    PATH_STATE_ACTIVE = 5'b10000
  } dpi_path_state_t;

  typedef struct packed {
    logic shutdown;
    logic deactivate;
    logic [3:0] app;
  } dpi_lane_ctl_t;

  typedef struct packed {
    logic [3:0] code;
    logic tx_en;
    logic changed;
  } dpi_lane_stat_t;

endpackage

// ===== hdl/dpi_lane.sv
// One data path state machine of the init sequencer.
`timescale 1ns/1ps
module dpi_lane
  import dpi_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control from the register file.
  input wire dpi_lane_ctl_t ctl_i,
  // Status and applied configuration.
  output dpi_lane_stat_t stat_o,
  output logic [3:0] cfg_o
);

  dpi_path_state_t state_reg;
  dpi_path_state_t state_next;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic [3:0] cfg_reg;
  logic tx_en_reg;
  logic changed_reg;
  logic cnt_zero;

  assign cnt_zero = (cnt_reg == 8'h00);

  // A shutdown request wins in every state, so a lane never lingers half set up.
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_zero ? cnt_reg : cnt_reg - 8'h01;
    unique case (state_reg)
      PATH_STATE_INACTIVE:
      begin
        if (!ctl_i.shutdown && ctl_i.app != 4'h0)
        begin
          state_next = PATH_STATE_INITIALIZING;
          cnt_next = 8'(DPI_INIT_CYC - 1);
        end
      end
      PATH_STATE_INITIALIZING:
      begin
        if (ctl_i.shutdown)
          state_next = PATH_STATE_INACTIVE;
        else if (cnt_zero)
          state_next = PATH_STATE_READY_IDLE;
      end
      PATH_STATE_READY_IDLE:
      begin
        if (ctl_i.shutdown)
          state_next = PATH_STATE_INACTIVE;
        else if (!ctl_i.deactivate)
        begin
          state_next = PATH_STATE_TRANSMITTER_ON;
          cnt_next = 8'(DPI_TXON_CYC - 1);
        end
      end
      PATH_STATE_TRANSMITTER_ON:
      begin
        if (ctl_i.shutdown)
          state_next = PATH_STATE_INACTIVE;
        else if (ctl_i.deactivate)
          state_next = PATH_STATE_READY_IDLE;
        else if (cnt_zero)
          state_next = PATH_STATE_ACTIVE;
      end
      PATH_STATE_ACTIVE:
      begin
        if (ctl_i.shutdown)
          state_next = PATH_STATE_INACTIVE;
        else if (ctl_i.deactivate)
          state_next = PATH_STATE_READY_IDLE;
      end
      default:
        state_next = PATH_STATE_INACTIVE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= PATH_STATE_INACTIVE;
      cnt_reg <= 8'h00;
      cfg_reg <= 4'h0;
      tx_en_reg <= 1'b0;
      changed_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      if (state_next == PATH_STATE_INITIALIZING && state_reg == PATH_STATE_INACTIVE)
        cfg_reg <= ctl_i.app;
      tx_en_reg <= (state_next == PATH_STATE_TRANSMITTER_ON) ||
                   (state_next == PATH_STATE_ACTIVE);
      changed_reg <= (state_next != state_reg) &&
                     ((state_next == PATH_STATE_ACTIVE) ||
                      (state_next == PATH_STATE_INACTIVE));
    end
  end

  assign stat_o.code = (state_reg == PATH_STATE_INITIALIZING) ? DPI_CODE_INITIALIZING :
                       (state_reg == PATH_STATE_READY_IDLE) ? DPI_CODE_READY_IDLE :
                       (state_reg == PATH_STATE_TRANSMITTER_ON) ? DPI_CODE_TX_ON :
                       (state_reg == PATH_STATE_ACTIVE) ? DPI_CODE_ACTIVE :
                       DPI_CODE_INACTIVE;
  assign stat_o.tx_en = tx_en_reg;
  assign stat_o.changed = changed_reg;
  assign cfg_o = cfg_reg;

endmodule

// ===== hdl/dpi_seq.sv
// Data path init sequencer: AXI4-Lite register file, commit logic and lanes.
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - A commit checks the staged code per lane and copies a valid one to the active set if the lane is inactive.
// - An invalid staged code is not copied; on an inactive lane the error code field reports it, on a busy lane it reports busy.
// - When the shutdown condition goes false each affected lane with a nonzero active code moves to initializing.
// - In initializing a lane sets itself up from the active code, then is ready idle.
// - From ready idle with the deactivate condition false a lane enters transmitter on.
// - In transmitter on the lane enables its transmit output, then goes active.
// - Entry into active sets the lane's state changed interrupt flag.
// - Software reads the interrupt flags on an interrupt, and those reads release the line.
module dpi_seq
  import dpi_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // AXI4-Lite write address and data.
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read.
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Module level state, from a pin.
  input wire logic module_state_operational_i,
  // Data path outputs.
  output logic [DPI_LANES-1:0] tx_enable_o,
  output logic module_interrupt_n_o
);

  logic aw_hold_reg;
  logic [7:0] aw_addr_reg;
  logic w_hold_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  logic [31:0] staged_reg;
  logic [7:0] shutdown_reg;
  logic [7:0] tx_dis_reg;
  logic [7:0] int_stat_reg;
  logic [7:0] int_stat_next;
  logic [7:0] int_en_reg;
  logic int_n_reg;
  logic op_meta_reg;
  logic op_sync_reg;

  logic [31:0] active_w;
  logic [31:0] err_w;
  logic [31:0] path_state_w;
  logic [7:0] changed_w;
  logic [7:0] tx_en_w;

  // Write side decode.
  logic wr_fire;
  logic wr_staged;
  logic wr_commit;
  logic wr_shutdown;
  logic wr_int_clr;
  logic wr_int_en;
  logic wr_tx_dis;
  logic wr_mapped;
  logic [31:0] wr_mask;
  logic [7:0] commit_lanes;
  logic [7:0] int_clr_bits;

  assign wr_fire = aw_hold_reg & w_hold_reg & ~bvalid_reg;
  assign wr_staged = wr_fire & (aw_addr_reg == DPI_OFS_STAGED);
  assign wr_commit = wr_fire & (aw_addr_reg == DPI_OFS_COMMIT) & w_strb_reg[0];
  assign wr_shutdown = wr_fire & (aw_addr_reg == DPI_OFS_SHUTDOWN) & w_strb_reg[0];
  assign wr_int_clr = wr_fire & (aw_addr_reg == DPI_OFS_INT_CLR) & w_strb_reg[0];
  assign wr_int_en = wr_fire & (aw_addr_reg == DPI_OFS_INT_EN) & w_strb_reg[0];
  assign wr_tx_dis = wr_fire & (aw_addr_reg == DPI_OFS_TX_DIS) & w_strb_reg[0];
  // Read-only registers answer a write with OKAY and ignore the data.
  assign wr_mapped = (aw_addr_reg == DPI_OFS_STAGED) || (aw_addr_reg == DPI_OFS_ACTIVE) ||
                     (aw_addr_reg == DPI_OFS_COMMIT) || (aw_addr_reg == DPI_OFS_CFG_ERR) ||
                     (aw_addr_reg == DPI_OFS_SHUTDOWN) ||
                     (aw_addr_reg == DPI_OFS_PATH_STATE) ||
                     (aw_addr_reg == DPI_OFS_INT_STAT) || (aw_addr_reg == DPI_OFS_INT_CLR) ||
                     (aw_addr_reg == DPI_OFS_INT_EN) || (aw_addr_reg == DPI_OFS_TX_DIS);
  assign wr_mask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                    {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  assign commit_lanes = wr_commit ? w_data_reg[7:0] : 8'h00;
  assign int_clr_bits = wr_int_clr ? w_data_reg[7:0] : 8'h00;

  // Read side decode.
  logic rd_take;
  logic rd_int_stat;
  logic rd_mapped;
  logic [31:0] rd_data;

  assign rd_take = s_axi_arvalid_i & ~rvalid_reg;
  assign rd_int_stat = rd_take & (s_axi_araddr_i == DPI_OFS_INT_STAT);
  assign rd_mapped = (s_axi_araddr_i == DPI_OFS_STAGED) ||
                     (s_axi_araddr_i == DPI_OFS_ACTIVE) ||
                     (s_axi_araddr_i == DPI_OFS_COMMIT) ||
                     (s_axi_araddr_i == DPI_OFS_CFG_ERR) ||
                     (s_axi_araddr_i == DPI_OFS_SHUTDOWN) ||
                     (s_axi_araddr_i == DPI_OFS_PATH_STATE) ||
                     (s_axi_araddr_i == DPI_OFS_INT_STAT) ||
                     (s_axi_araddr_i == DPI_OFS_INT_CLR) ||
                     (s_axi_araddr_i == DPI_OFS_INT_EN) ||
                     (s_axi_araddr_i == DPI_OFS_TX_DIS);
  // Write-only registers read as zero.
  assign rd_data = (s_axi_araddr_i == DPI_OFS_STAGED) ? staged_reg :
                   (s_axi_araddr_i == DPI_OFS_ACTIVE) ? active_w :
                   (s_axi_araddr_i == DPI_OFS_CFG_ERR) ? err_w :
                   (s_axi_araddr_i == DPI_OFS_SHUTDOWN) ? {24'h0, shutdown_reg} :
                   (s_axi_araddr_i == DPI_OFS_PATH_STATE) ? path_state_w :
                   (s_axi_araddr_i == DPI_OFS_INT_STAT) ? {24'h0, int_stat_reg} :
                   (s_axi_araddr_i == DPI_OFS_INT_EN) ? {24'h0, int_en_reg} :
                   (s_axi_araddr_i == DPI_OFS_TX_DIS) ? {24'h0, tx_dis_reg} :
                   32'h0;

  // A new state change wins over a clear in the same cycle.
  assign int_stat_next = (int_stat_reg & ~int_clr_bits &
                          ~{8{rd_int_stat}}) | changed_w;

  assign s_axi_awready_o = ~aw_hold_reg;
  assign s_axi_wready_o = ~w_hold_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_arready_o = ~rvalid_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;
  assign tx_enable_o = tx_en_w;
  assign module_interrupt_n_o = int_n_reg;

  // Write channel: address and data are caught in either order.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid_i && !aw_hold_reg)
      begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr_i[7:2], 2'b00};
      end
      else if (wr_fire)
        aw_hold_reg <= 1'b0;
      if (s_axi_wvalid_i && !w_hold_reg)
      begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_i;
        w_strb_reg <= s_axi_wstrb_i;
      end
      else if (wr_fire)
        w_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= DPI_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_mapped ? DPI_RESP_OKAY : DPI_RESP_SLVERR;
    end
    else if (s_axi_bready_i)
      bvalid_reg <= 1'b0;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= DPI_RESP_OKAY;
    end
    else if (rd_take)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_data;
      rresp_reg <= rd_mapped ? DPI_RESP_OKAY : DPI_RESP_SLVERR;
    end
    else if (s_axi_rready_i)
      rvalid_reg <= 1'b0;
  end

  // Control registers.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      staged_reg <= DPI_STAGED_RST;
      shutdown_reg <= DPI_SHUTDOWN_RST;
      tx_dis_reg <= DPI_TX_DIS_RST;
      int_en_reg <= DPI_INT_EN_RST;
    end
    else
    begin
      if (wr_staged)
        staged_reg <= (staged_reg & ~wr_mask) | (w_data_reg & wr_mask);
      if (wr_shutdown)
        shutdown_reg <= w_data_reg[7:0];
      if (wr_tx_dis)
        tx_dis_reg <= w_data_reg[7:0];
      if (wr_int_en)
        int_en_reg <= w_data_reg[7:0];
    end
  end

  // The interrupt line is registered so it never glitches on decode.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      int_stat_reg <= 8'h00;
      int_n_reg <= 1'b1;
    end
    else
    begin
      int_stat_reg <= int_stat_next;
      int_n_reg <= ~|(int_stat_next & int_en_reg);
    end
  end

  // The module state comes from outside this clock, so it is synchronised.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      op_meta_reg <= 1'b0;
      op_sync_reg <= 1'b0;
    end
    else
    begin
      op_meta_reg <= module_state_operational_i;
      op_sync_reg <= op_meta_reg;
    end
  end

  // Per-lane commit logic and data path state machine.
  for (genvar g = 0; g < DPI_LANES; g++)
  begin : g_lane
    logic [3:0] act_reg;
    logic [3:0] err_reg;
    logic [3:0] staged_code;
    logic code_ok;
    logic lane_busy;
    dpi_lane_ctl_t ctl;
    dpi_lane_stat_t stat;

    assign staged_code = staged_reg[4*g +: 4];
    assign code_ok = DPI_APP_VALID[staged_code];
    // A lane that is not inactive keeps its running set; the commit is refused.
    assign lane_busy = (stat.code != DPI_CODE_INACTIVE);

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
      begin
        act_reg <= 4'h0;
        err_reg <= DPI_ERR_NONE;
      end
      else if (commit_lanes[g])
      begin
        if (lane_busy)
          err_reg <= DPI_ERR_BUSY;
        else if (code_ok)
        begin
          act_reg <= staged_code;
          err_reg <= DPI_ERR_ACCEPTED;
        end
        else
          err_reg <= DPI_ERR_BAD_CODE;
      end
    end

    // Shutdown holds while the module is not operational or software asks for it.
    assign ctl.shutdown = shutdown_reg[g] | ~op_sync_reg;
    assign ctl.deactivate = shutdown_reg[g] | ~op_sync_reg | tx_dis_reg[g];
    assign ctl.app = act_reg;

    dpi_lane u_lane (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .ctl_i(ctl),
      .stat_o(stat),
      .cfg_o()
    );

    assign active_w[4*g +: 4] = act_reg;
    assign err_w[4*g +: 4] = err_reg;
    assign path_state_w[4*g +: 4] = stat.code;
    assign changed_w[g] = stat.changed;
    assign tx_en_w[g] = stat.tx_en;
  end

endmodule

// ===== test/dpi_seq_checker.sv
// Concurrent checks on the ports of the data path init sequencer.
`timescale 1ns/1ps
module dpi_seq_checker
  import dpi_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register bus.
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Lanes and interrupt.
  input wire logic module_state_operational_i,
  input wire logic [DPI_LANES-1:0] tx_enable_o,
  input wire logic module_interrupt_n_o
);
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  logic [8:0] op_cnt_reg;
  logic [8:0] op_cnt_next;
  logic stat_rd;

  // Saturates so that a long operational spell never wraps back under the init time.
  assign op_cnt_next = !module_state_operational_i ? 9'h000 :
    (op_cnt_reg == 9'h1ff) ? op_cnt_reg : op_cnt_reg + 9'h001;
  assign stat_rd = s_axi_arvalid_i && s_axi_arready_o && (s_axi_araddr_i == DPI_OFS_INT_STAT);

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      op_cnt_reg <= 9'h000;
    else
      op_cnt_reg <= op_cnt_next;
  end

  sequence s_tx_up;
    $rose(tx_enable_o[0]);
  endsequence
  sequence s_int_low;
    ##[49:53] !module_interrupt_n_o;
  endsequence

  property p_int_release;
    stat_rd |=> module_interrupt_n_o;
  endproperty
  property p_int_hold;
    !module_interrupt_n_o && !stat_rd && s_axi_awready_o && !s_axi_awvalid_i
      |=> !module_interrupt_n_o;
  endproperty
  property p_tx_to_int;
    s_tx_up |-> s_int_low;
  endproperty
  // Lanes cannot leave init before the set-up time has passed since operation began.
  property p_no_early_tx;
    (op_cnt_reg >= 9'h008) && (op_cnt_reg < 9'(DPI_INIT_CYC)) |-> tx_enable_o == '0;
  endproperty
  property p_deact;
    $fell(module_state_operational_i) |-> ##[1:5] tx_enable_o == '0;
  endproperty
  property p_bvalid_hold;
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o;
  endproperty
  property p_rvalid_hold;
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o;
  endproperty
  property p_rd_answer;
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
  endproperty

  a_int_release: assert property (p_int_release)
    else $error("interrupt kept after status read");
  a_int_hold: assert property (p_int_hold)
    else $error("interrupt dropped with flags pending");
  a_tx_to_int: assert property (p_tx_to_int)
    else $error("no interrupt after transmitter turn-on");
  a_no_early_tx: assert property (p_no_early_tx)
    else $error("transmit enabled before set-up time");
  a_deact: assert property (p_deact)
    else $error("transmit kept when not operational");
  a_bvalid_hold: assert property (p_bvalid_hold)
    else $error("write response withdrawn");
  a_rvalid_hold: assert property (p_rvalid_hold)
    else $error("read data withdrawn");
  a_rd_answer: assert property (p_rd_answer)
    else $error("read not answered in one cycle");
endmodule

// ===== test/dpi_host.sv
// Host controller model that reaches the sequencer registers over the register bus.
`timescale 1ns/1ps
module dpi_host
(
  // Clock.
  input wire logic clk_i,
  // Write channels.
  output logic [7:0] awaddr_o,
  output logic awvalid_o,
  input wire logic awready_i,
  output logic [31:0] wdata_o,
  output logic [3:0] wstrb_o,
  output logic wvalid_o,
  input wire logic wready_i,
  input wire logic [1:0] bresp_i,
  input wire logic bvalid_i,
  output logic bready_o,
  // Read channels.
  output logic [7:0] araddr_o,
  output logic arvalid_o,
  input wire logic arready_i,
  input wire logic [31:0] rdata_i,
  input wire logic [1:0] rresp_i,
  input wire logic rvalid_i,
  output logic rready_o
);
  // Cycles the host lets a response wait, to exercise a slow host.
  int slow = 0;

  initial
  begin
    awaddr_o = 8'h00;
    awvalid_o = 1'b0;
    wdata_o = 32'h0000_0000;
    wstrb_o = 4'h0;
    wvalid_o = 1'b0;
    bready_o = 1'b0;
    araddr_o = 8'h00;
    arvalid_o = 1'b0;
    rready_o = 1'b0;
  end

  // Released payloads are inverted so that a stale value is never mistaken for a live one.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw_done;
    bit w_done;
    aw_done = 0;
    w_done = 0;
    awaddr_o <= a;
    awvalid_o <= 1'b1;
    wdata_o <= d;
    wstrb_o <= 4'hf;
    wvalid_o <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge clk_i);
      if (!aw_done && awready_i === 1'b1)
      begin
        aw_done = 1;
        awvalid_o <= 1'b0;
        awaddr_o <= ~a;
      end
      if (!w_done && wready_i === 1'b1)
      begin
        w_done = 1;
        wvalid_o <= 1'b0;
        wdata_o <= ~d;
      end
    end
    repeat (slow) @(posedge clk_i);
    bready_o <= 1'b1;
    do @(posedge clk_i); while (bvalid_i !== 1'b1);
    r = bresp_i;
    bready_o <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    do @(posedge clk_i); while (arready_i !== 1'b1);
    arvalid_o <= 1'b0;
    araddr_o <= ~a;
    repeat (slow) @(posedge clk_i);
    rready_o <= 1'b1;
    do @(posedge clk_i); while (rvalid_i !== 1'b1);
    d = rdata_i;
    r = rresp_i;
    rready_o <= 1'b0;
  endtask
endmodule

// ===== test/dpi_seq_tb.sv
// Self-checking bench for the data path init sequencer.
`timescale 1ns/1ps
module dpi_seq_tb
  import dpi_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
  logic [3:0] s_axi_wstrb_i;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
  logic s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
  logic s_axi_rvalid_o, s_axi_rready_i, module_interrupt_n_o;
  logic module_state_operational_i = 1'b0;
  logic [DPI_LANES-1:0] tx_enable_o;
  int error_cnt = 0;
  int checked = 0;

  always #2 clk_i = ~clk_i;

  dpi_seq dut (.*);
  dpi_host host (
    .clk_i(clk_i),
    .awaddr_o(s_axi_awaddr_i),
    .awvalid_o(s_axi_awvalid_i),
    .awready_i(s_axi_awready_o),
    .wdata_o(s_axi_wdata_i),
    .wstrb_o(s_axi_wstrb_i),
    .wvalid_o(s_axi_wvalid_i),
    .wready_i(s_axi_wready_o),
    .bresp_i(s_axi_bresp_o),
    .bvalid_i(s_axi_bvalid_o),
    .bready_o(s_axi_bready_i),
    .araddr_o(s_axi_araddr_i),
    .arvalid_o(s_axi_arvalid_i),
    .arready_i(s_axi_arready_o),
    .rdata_i(s_axi_rdata_o),
    .rresp_i(s_axi_rresp_o),
    .rvalid_i(s_axi_rvalid_o),
    .rready_o(s_axi_rready_i)
  );

  task automatic cmp_w(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er,
                        input string what);
    logic [31:0] d;
    logic [1:0] r;
    host.rd(a, d, r);
    cmp_w(d, exp, what);
    cmp_w({30'h0, r}, {30'h0, er}, what);
  endtask

  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er,
                        input string what);
    logic [1:0] r;
    host.wr(a, d, r);
    cmp_w({30'h0, r}, {30'h0, er}, what);
  endtask

  task automatic wait_int(input logic lvl, input int lim);
    for (int i = 0; i < lim && module_interrupt_n_o !== lvl; i++)
      @(posedge clk_i);
  endtask

  task automatic t_reset_regs();
    rd_chk(DPI_OFS_SHUTDOWN, {24'h0, DPI_SHUTDOWN_RST}, DPI_RESP_OKAY, "shutdown reset");
    rd_chk(DPI_OFS_INT_EN, {24'h0, DPI_INT_EN_RST}, DPI_RESP_OKAY, "int enable reset");
    rd_chk(DPI_OFS_PATH_STATE, {8{DPI_CODE_INACTIVE}}, DPI_RESP_OKAY, "idle lanes");
    rd_chk(8'h40, 32'h0, DPI_RESP_SLVERR, "unmapped read");
    wr_chk(8'h40, 32'hffff_ffff, DPI_RESP_SLVERR, "unmapped write");
  endtask

  // Lane 7 is staged with an unsupported code and must stay behind.
  task automatic t_bring_up();
    wr_chk(DPI_OFS_SHUTDOWN, 32'h0000_00ff, DPI_RESP_OKAY, "hold lanes");
    module_state_operational_i <= 1'b1;
    // The host's own transmitters are taken as stable from here on, before the commit.
    wr_chk(DPI_OFS_STAGED, 32'h4321_3213, DPI_RESP_OKAY, "stage");
    wr_chk(DPI_OFS_COMMIT, {24'h0, DPI_COMMIT_ALL}, DPI_RESP_OKAY, "commit");
    rd_chk(DPI_OFS_CFG_ERR, {DPI_ERR_BAD_CODE, {7{DPI_ERR_ACCEPTED}}}, DPI_RESP_OKAY,
           "config errors");
    rd_chk(DPI_OFS_ACTIVE, 32'h0321_3213, DPI_RESP_OKAY, "active set");
    rd_chk(DPI_OFS_PATH_STATE, {8{DPI_CODE_INACTIVE}}, DPI_RESP_OKAY, "held");
    wr_chk(DPI_OFS_SHUTDOWN, 32'h0, DPI_RESP_OKAY, "release lanes");
    rd_chk(DPI_OFS_PATH_STATE, {DPI_CODE_INACTIVE, {7{DPI_CODE_INITIALIZING}}}, DPI_RESP_OKAY,
           "init entered");
    repeat (200) @(posedge clk_i);
    cmp_w({24'h0, tx_enable_o}, 32'h0, "tx during init");
    wait_int(1'b0, 400);
    cmp_w({31'h0, module_interrupt_n_o}, 32'h0, "interrupt on active");
    cmp_w({24'h0, tx_enable_o}, 32'h0000_007f, "tx on");
    rd_chk(DPI_OFS_PATH_STATE, {DPI_CODE_INACTIVE, {7{DPI_CODE_ACTIVE}}}, DPI_RESP_OKAY,
           "active");
    rd_chk(DPI_OFS_INT_STAT, 32'h0000_007f, DPI_RESP_OKAY, "flags");
    cmp_w({31'h0, module_interrupt_n_o}, 32'h1, "released by read");
    rd_chk(DPI_OFS_INT_STAT, 32'h0, DPI_RESP_OKAY, "cleared by read");
  endtask

  // A second commit on running lanes must be refused; a slow host also stalls answers here.
  task automatic t_busy();
    host.slow = 3;
    wr_chk(DPI_OFS_COMMIT, {24'h0, DPI_COMMIT_ALL}, DPI_RESP_OKAY, "recommit");
    rd_chk(DPI_OFS_CFG_ERR, {DPI_ERR_BAD_CODE, {7{DPI_ERR_BUSY}}}, DPI_RESP_OKAY,
           "busy errors");
    wr_chk(DPI_OFS_ACTIVE, 32'h0, DPI_RESP_OKAY, "read-only write");
    rd_chk(DPI_OFS_ACTIVE, 32'h0321_3213, DPI_RESP_OKAY, "active kept");
    host.slow = 0;
  endtask

  // Holding transmitters off returns running lanes to ready idle; the release re-activates.
  task automatic t_tx_dis();
    wr_chk(DPI_OFS_TX_DIS, 32'h0000_00ff, DPI_RESP_OKAY, "tx disable");
    rd_chk(DPI_OFS_PATH_STATE, {DPI_CODE_INACTIVE, {7{DPI_CODE_READY_IDLE}}}, DPI_RESP_OKAY,
           "back to ready idle");
    cmp_w({24'h0, tx_enable_o}, 32'h0, "tx held off");
    wr_chk(DPI_OFS_TX_DIS, 32'h0, DPI_RESP_OKAY, "tx release");
    wait_int(1'b0, 100);
    cmp_w({24'h0, tx_enable_o}, 32'h0000_007f, "tx on again");
    rd_chk(DPI_OFS_INT_STAT, 32'h0000_007f, DPI_RESP_OKAY, "flags again");
  endtask

  task automatic t_irq_mask();
    wr_chk(DPI_OFS_INT_EN, 32'h0, DPI_RESP_OKAY, "mask");
    module_state_operational_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    cmp_w({24'h0, tx_enable_o}, 32'h0, "tx when not operational");
    cmp_w({31'h0, module_interrupt_n_o}, 32'h1, "masked");
    wr_chk(DPI_OFS_INT_EN, 32'h0000_00ff, DPI_RESP_OKAY, "unmask");
    wait_int(1'b0, 10);
    cmp_w({31'h0, module_interrupt_n_o}, 32'h0, "unmasked");
    wr_chk(DPI_OFS_INT_CLR, 32'h0000_00ff, DPI_RESP_OKAY, "clear");
    wait_int(1'b1, 10);
    cmp_w({31'h0, module_interrupt_n_o}, 32'h1, "cleared");
  endtask

  task automatic give_verdict();
    if (error_cnt == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset_regs();
    t_bring_up();
    t_busy();
    t_tx_dis();
    t_irq_mask();
    give_verdict();
  end

  // The whole run needs about five hundred cycles; this limit leaves ample room.
  initial
  begin
    repeat (5000) @(posedge clk_i);
    error_cnt++;
    give_verdict();
  end
endmodule

bind dpi_seq dpi_seq_checker chk (.*);
